// [rx_fifo.sv]
// Receive slice output FIFO: deserializer, eight-entry pointer FIFO, empty
// synchronizer, APB control and status registers and one interrupt.
// Assumes serial samples and the reader's clock tick are synchronous to clk.
// ****************************************************************
// Functional notes
// ****************************************************************
// Functional notes
// RULE1: Width 4 gives low nibble plus serial copy.
// RULE2: Non-sync mode crosses into the reader's timing.
// RULE3: Latency typically two read cycles, up to eight.
// RULE4: Writes use divided sample clock, copy forwarded.
// RULE5: Forwarded write clock usable only at position zero.
// RULE6: Reader supplies same-rate clock, any phase.
// RULE7: Read pointer moves only with read enable.
// RULE8: Write pointer wraps after eight positions.
// RULE9: Empty when both pointers are equal.
// RULE10: Empty is resynchronized over two read cycles.
// RULE11: Write pointer always leads read pointer. Here the write pointer never waits and laps a stalled reader.
// RULE12: Single clock: register inverted farthest empty.
// RULE13: Multiple clocks: register NOR of empties.
// RULE14: Start application after ready status rises.
// RULE15: Hold receive clock until ready asserted.
// RULE16: Uncontrolled transmitter needs bit-slip alignment.
// RULE17: Latency depends on read clock phase.
// RULE18: Read side updates on read edges.
//
// The APB interface to the registers and the placing of the registers were decided locally.
module rx_fifo #(
    parameter int NIBBLE_POS = 0
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        serial_in,
    input  wire logic        rd_tick,
    input  wire logic        rd_en,
    output logic      [7:0]  q,
    output logic             empty,
    output logic             wrclk_out,
    output logic             irq
);

    localparam int AW = $clog2(rx_fifo_pkg::FIFO_DEPTH);

    // ****************************************************************
    // Registers and bus decode
    // ****************************************************************
    logic [2:0]                      ctrl;
    logic [rx_fifo_pkg::EV_COUNT-1:0] status;
    logic [rx_fifo_pkg::EV_COUNT-1:0] mask;
    logic [rx_fifo_pkg::EV_COUNT-1:0] ev_set;
    logic                            width8;
    logic                            sync_mode;
    logic                            run;
    logic                            setup;
    logic                            wr_access;
    logic                            mapped;
    logic [31:0]                     next_prdata;

    assign width8    = ctrl[rx_fifo_pkg::CTRL_WIDTH8_BIT];
    assign sync_mode = ctrl[rx_fifo_pkg::CTRL_SYNC_BIT];
    assign run       = ctrl[rx_fifo_pkg::CTRL_RUN_BIT];
    assign setup     = psel && !penable;
    assign wr_access = psel && penable && pwrite;
    assign mapped    = (paddr == rx_fifo_pkg::CTRL_OFFSET) || (paddr == rx_fifo_pkg::STATUS_OFFSET)
                    || (paddr == rx_fifo_pkg::MASK_OFFSET) || (paddr == rx_fifo_pkg::PTRS_OFFSET);

    // ****************************************************************
    // FIFO datapath signals
    // ****************************************************************
    logic          wr_tick;
    logic          wr_level;
    logic          rd_step;
    logic          rd_clk_en;
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    logic [7:0]    shifter;
    logic [7:0]    wdata;
    logic [7:0]    rdata;
    logic          ptr_equal;
    logic          empty_s1;
    logic          empty_d;
    logic [7:0]    filled;
    logic          rdata_ok;
    logic [7:0]    rd_word;

    always_comb begin
        next_prdata = 32'h0;
        unique case (paddr)
            rx_fifo_pkg::CTRL_OFFSET:   next_prdata = {29'h0, ctrl};
            rx_fifo_pkg::STATUS_OFFSET: next_prdata = {30'h0, status};
            rx_fifo_pkg::MASK_OFFSET:   next_prdata = {30'h0, mask};
            rx_fifo_pkg::PTRS_OFFSET:   next_prdata = {24'h0, empty, wptr, 1'b0, rptr};
            default:                    next_prdata = 32'h0;
        endcase
    end

    // Read data and error are set up in the setup cycle so the zero-wait access sees them from flops.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            prdata  <= 32'h0;
            pslverr <= 1'b0;
            pready  <= 1'b0;
        end else begin
            pready <= 1'b1;
            if (setup) begin
                prdata  <= pwrite ? 32'h0 : next_prdata;
                pslverr <= !mapped;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctrl <= rx_fifo_pkg::CTRL_RESET;
            mask <= rx_fifo_pkg::MASK_RESET;
        end else if (wr_access) begin
            if (paddr == rx_fifo_pkg::CTRL_OFFSET) begin
                ctrl <= pwdata[2:0];
            end
            if (paddr == rx_fifo_pkg::MASK_OFFSET) begin
                mask <= pwdata[rx_fifo_pkg::EV_COUNT-1:0];
            end
        end
    end

    // ****************************************************************
    // Events and interrupt
    // ****************************************************************
    assign ev_set[rx_fifo_pkg::EV_EMPTY_RISE] = empty && !empty_d;
    assign ev_set[rx_fifo_pkg::EV_EMPTY_FALL] = !empty && empty_d;

    // A new event in the clearing cycle survives: the set term is applied after the clear.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            status <= '0;
        end else if (wr_access && paddr == rx_fifo_pkg::STATUS_OFFSET) begin
            status <= (status & ~pwdata[rx_fifo_pkg::EV_COUNT-1:0]) | ev_set;
        end else begin
            status <= status | ev_set;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irq     <= 1'b0;
            empty_d <= 1'b1;
        end else begin
            irq     <= |(status & mask);
            empty_d <= empty;
        end
    end

    // ****************************************************************
    // Write side: deserializer and divided sample clock
    // ****************************************************************
    sample_divider u_div (
        .clk    (clk),
        .rst_n  (rst_n),
        .run    (run),
        .width8 (width8),
        .tick   (wr_tick),
        .level  (wr_level)
    );

    assign wdata = width8 ? {shifter[6:0], serial_in} : {4'h0, shifter[2:0], serial_in}; // RULE1

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            shifter <= 8'h0;
        end else begin
            shifter <= {shifter[6:0], serial_in};
        end
    end

    // The write pointer never waits for the reader; a stalled reader simply sees overwritten words.
    always_ff @(posedge clk) begin
        if (!rst_n || !run) begin
            wptr <= '0;
        end else if (wr_tick) begin
            wptr <= wptr + AW'(1); // RULE7 RULE8 RULE4
        end
    end

    // Only the slice at nibble position zero drives its forwarded clock out.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wrclk_out <= 1'b0;
        end else begin
            wrclk_out <= (NIBBLE_POS == 0) ? wr_level : 1'b0; // RULE5 RULE4
        end
    end

    // ****************************************************************
    // Read side
    // ****************************************************************
    // In synchronous mode the reader runs on the write tick; otherwise on the reader's own tick.
    assign rd_clk_en = sync_mode ? wr_tick : rd_tick; // RULE2 RULE6
    assign rd_step   = rd_clk_en && rd_en;
    assign ptr_equal = (wptr == rptr); // RULE9

    fifo_mem #(
        .W (rx_fifo_pkg::WORD_WIDTH),
        .D (rx_fifo_pkg::FIFO_DEPTH)
    ) u_mem (
        .clk   (clk),
        .we    (wr_tick),
        .waddr (wptr),
        .wdata (wdata),
        .re    (rd_clk_en),
        .raddr (rptr),
        .rdata (rdata)
    );

    // A slot reads as zero until it has been written once, so power-up contents never reach q.
    // The flag is dropped only by reset: a stopped run leaves the stored words valid.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            filled <= 8'h0;
        end else if (wr_tick) begin
            filled[wptr] <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdata_ok <= 1'b0;
        end else if (rd_clk_en) begin
            rdata_ok <= filled[rptr]; // RULE18
        end
    end

    assign rd_word = rdata_ok ? rdata : 8'h0;

    always_ff @(posedge clk) begin
        if (!rst_n || !run) begin
            rptr <= '0;
        end else if (rd_step) begin
            rptr <= rptr + AW'(1); // RULE7 RULE18
        end
    end

    // Two-stage resynchronizer keeps the reader from stepping onto the write slot; latency
    // therefore depends on where the write tick falls relative to the read tick.
    always_ff @(posedge clk) begin
        if (!rst_n || !run) begin
            empty_s1 <= 1'b1;
            empty    <= 1'b1;
        end else if (rd_clk_en) begin
            empty_s1 <= ptr_equal; // RULE10 RULE11 RULE17
            empty    <= empty_s1; // RULE10 RULE18
        end
    end

    // Output word lands one cycle after the registered memory read.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            q <= 8'h0;
        end else if (width8) begin
            q <= rd_word; // RULE1 RULE3
        end else begin
            q                         <= {4'h0, rd_word[3:0]}; // RULE1
            q[rx_fifo_pkg::MIMIC_BIT] <= serial_in; // RULE1
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_read_step;
        rd_step && run;
    endsequence

    property p_wptr_wrap;
        (run && wr_tick && wptr == AW'(7)) |=> (wptr == '0);
    endproperty
    a_wptr_wrap: assert property (p_wptr_wrap) else $error("write pointer did not wrap"); // RULE8

    property p_wptr_adv;
        (run && wr_tick) ##1 run |-> (wptr == $past(wptr) + AW'(1));
    endproperty
    a_wptr_adv: assert property (p_wptr_adv) else $error("write pointer did not advance"); // RULE7

    property p_rptr_hold;
        (run && !rd_step) ##1 run |-> $stable(rptr);
    endproperty
    a_rptr_hold: assert property (p_rptr_hold) else $error("read pointer moved without enable"); // RULE7

    property p_rptr_step;
        s_read_step ##1 run |-> (rptr == $past(rptr) + AW'(1));
    endproperty
    a_rptr_step: assert property (p_rptr_step) else $error("read pointer did not step"); // RULE18

    property p_empty_sync;
        (run && rd_clk_en) ##1 run |-> (empty == $past(empty_s1));
    endproperty
    a_empty_sync: assert property (p_empty_sync) else $error("empty not taken from first stage"); // RULE10

    property p_empty_hold;
        (run && !rd_clk_en) ##1 run |-> $stable(empty);
    endproperty
    a_empty_hold: assert property (p_empty_hold) else $error("empty changed off read tick"); // RULE10

    property p_width4_format;
        (!width8) |=> (q[7:6] == 2'h0 && q[4] == 1'b0 && q[5] == $past(serial_in));
    endproperty
    a_width4_format: assert property (p_width4_format) else $error("width 4 output format wrong"); // RULE1

    property p_width8_data;
        (width8) |=> (q == $past(rd_word));
    endproperty
    a_width8_data: assert property (p_width8_data) else $error("width 8 output not full word"); // RULE1

    property p_wrclk_pos;
        (NIBBLE_POS != 0) |-> (wrclk_out == 1'b0);
    endproperty
    a_wrclk_pos: assert property (p_wrclk_pos) else $error("forwarded clock driven off position zero"); // RULE5

    property p_tick_spacing;
        wr_tick |=> !wr_tick [*3];
    endproperty
    a_tick_spacing: assert property (p_tick_spacing) else $error("write ticks closer than a word"); // RULE4

    property p_irq;
        ##1 (irq == |($past(status) & $past(mask)));
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt does not follow masked status");

    property p_empty_equal;
        (run && rd_clk_en) |=> (empty_s1 == $past(ptr_equal));
    endproperty
    a_empty_equal: assert property (p_empty_equal) else $error("empty first stage missed pointer match"); // RULE9

    property p_status_set;
        (ev_set != '0) |=> ((status & $past(ev_set)) == $past(ev_set));
    endproperty
    a_status_set: assert property (p_status_set) else $error("event lost in clearing cycle");

endmodule

// [rx_fifo_pkg.sv]
// Shared constants for the receive slice output FIFO.
// Assumes a single 25 MHz clock and an APB register port.
package rx_fifo_pkg;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [11:0] CTRL_OFFSET   = 12'h000;
    localparam logic [11:0] STATUS_OFFSET = 12'h004;
    localparam logic [11:0] MASK_OFFSET   = 12'h008;
    localparam logic [11:0] PTRS_OFFSET   = 12'h00c;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int CTRL_WIDTH8_BIT = 0;
    localparam int CTRL_SYNC_BIT   = 1;
    localparam int CTRL_RUN_BIT    = 2;
    localparam int EV_EMPTY_RISE   = 0;
    localparam int EV_EMPTY_FALL   = 1;
    localparam int EV_COUNT        = 2;
    localparam int MIMIC_BIT       = 5;

    // ****************************************************************
    // Reset values and counts
    // ****************************************************************
    localparam logic [2:0]          CTRL_RESET   = 3'h1;
    localparam logic [EV_COUNT-1:0] MASK_RESET   = 2'h0;
    localparam int                  FIFO_DEPTH   = 8;
    localparam int                  WORD_WIDTH   = 8;
    localparam logic [2:0]          LAST_BIT_W8  = 3'h7;
    localparam logic [2:0]          LAST_BIT_W4  = 3'h3;

endpackage

// [fifo_mem.sv]
// Small storage array for the receive FIFO with a registered read port.
// Assumes write and read strobes are one-cycle enables on the same clock.
module fifo_mem #(
    parameter int W = 8,
    parameter int D = 8
) (
    input  wire logic                 clk,
    input  wire logic                 we,
    input  wire logic [$clog2(D)-1:0] waddr,
    input  wire logic [W-1:0]         wdata,
    input  wire logic                 re,
    input  wire logic [$clog2(D)-1:0] raddr,
    output logic      [W-1:0]         rdata
);

    logic [W-1:0] mem [D];

    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    // Read data is sampled every read tick, so a locked pointer still shows refreshed words.
    always_ff @(posedge clk) begin
        if (re) begin
            rdata <= mem[raddr];
        end
    end

endmodule

// [sample_divider.sv]
// Divided sample clock generator: one write tick per deserialized word.
// Assumes one serial sample arrives on every clock edge while running.
module sample_divider (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic run,
    input  wire logic width8,
    output logic      tick,
    output logic      level
);

    logic [2:0] cnt;
    logic [2:0] last;

    assign last = width8 ? rx_fifo_pkg::LAST_BIT_W8 : rx_fifo_pkg::LAST_BIT_W4;

    always_ff @(posedge clk) begin
        if (!rst_n || !run) begin
            cnt <= 3'h0;
        end else if (cnt >= last) begin
            cnt <= 3'h0;
        end else begin
            cnt <= cnt + 3'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n || !run) begin
            tick  <= 1'b0;
            level <= 1'b0;
        end else begin
            tick  <= (cnt == last);
            level <= (cnt < (last >> 1) + 3'h1);
        end
    end

endmodule

// [rx_reader_model.sv]
// Reader-side model: a same-rate read tick at a chosen phase and a registered read enable.
// Assumes the FIFO empty flag is a register on the shared clock.
module rx_reader_model (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       enable,
    input  wire logic       width8,
    input  wire logic [2:0] phase,
    input  wire logic       stall,
    input  wire logic       empty,
    output logic            rd_tick,
    output logic            rd_en
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] cnt;
    // ********************
    // Read clock and enable
    // ********************
    // The tick stands still until the link runs, so every slice starts aligned.
    always_ff @(posedge clk) begin
        if (!rst_n || !enable) begin
            cnt     <= 3'h0;
            rd_tick <= 1'b0;
        end else begin
            cnt     <= cnt + 3'h1;
            rd_tick <= ((cnt ^ phase) & (width8 ? 3'h7 : 3'h3)) == 3'h0;
        end
    end
    // A lone slice: inverted empty through one flip-flop; stall holds reading off.
    always_ff @(posedge clk) begin
        if (!rst_n || !enable) begin
            rd_en <= 1'b0;
        end else if (rd_tick) begin
            rd_en <= !empty && !stall;
        end
    end
endmodule

// [tb_top.sv]
// Testbench for the receive FIFO: register checks over APB and streaming runs.
// Assumes rx_fifo_pkg, rx_fifo and rx_reader_model are compiled before it.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, serial_in, rd_tick, rd_en;
    logic        empty, wrclk_out, wrclk_p1, irq, run, width8, stall, err, w8, sync_on, mon;
    logic        prev_empty, prev_tick, prev_ser, prev_wr;
    logic [2:0]  phase;
    logic [7:0]  q, prev_q, dmask, step;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, p1;
    int          num_errors, check_count, n, have_prev, chg, rises;

    rx_fifo #(.NIBBLE_POS(0)) i_dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .serial_in(serial_in), .rd_tick(rd_tick), .rd_en(rd_en), .q(q),
        .empty(empty), .wrclk_out(wrclk_out), .irq(irq));
    rx_fifo #(.NIBBLE_POS(1)) i_dut_p1 (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(), .pready(), .pslverr(),
        .serial_in(serial_in), .rd_tick(rd_tick), .rd_en(rd_en), .q(), .empty(),
        .wrclk_out(wrclk_p1), .irq());
    rx_reader_model i_reader (.clk(clk), .rst_n(rst_n), .enable(run), .width8(width8), .phase(phase),
        .stall(stall), .empty(empty), .rd_tick(rd_tick), .rd_en(rd_en));

    always #20 clk = ~clk;

    task automatic stop_test();
        if (num_errors == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic timed_out();
        num_errors++;
        $display("[ERR] %0t wait limit reached", $time);
        stop_test();
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 16);
        if (pready !== 1'b1) timed_out();
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Starts a run, waits for data to flow, then watches a window of twenty words.
    task automatic start(input logic [31:0] c, input logic [2:0] ph, input int per);
        int k;
        phase <= ph;
        dmask = (per == 8) ? 8'hff : 8'h0f;
        apb(1'b1, rx_fifo_pkg::CTRL_OFFSET, c);
        k = 0;
        while (empty !== 1'b0 && k < 8 * per + 8) begin
            @(posedge clk);
            k++;
        end
        if (k >= 8 * per + 8) timed_out();
        repeat (2 * per) @(posedge clk);
        have_prev = 0;
        step = 8'h1;
        chg = 0;
        rises = 0;
        mon = 1'b1;
        repeat (20 * per) @(posedge clk);
        check(chg >= 18, 1'b1);
        check(rises >= 19 && rises <= 21, 1'b1);
    endtask

    // ********************
    // Serial source and output monitor
    // ********************
    // Each control write restarts the stream one sample ahead of the divider, framing word k as k.
    always @(posedge clk) begin
        if (psel && penable && pwrite && paddr == rx_fifo_pkg::CTRL_OFFSET) begin
            n = -1;
            w8 = pwdata[rx_fifo_pkg::CTRL_WIDTH8_BIT];
            width8  <= pwdata[rx_fifo_pkg::CTRL_WIDTH8_BIT];
            sync_on <= pwdata[rx_fifo_pkg::CTRL_SYNC_BIT];
            run     <= pwdata[rx_fifo_pkg::CTRL_RUN_BIT];
        end
        serial_in <= w8 ? 1'((n >> 3) >> (7 - n % 8)) : 1'((n >> 2) >> (3 - n % 4));
        n++;
    end

    always @(posedge clk) begin
        if (mon) begin
            if (!sync_on && empty !== prev_empty) check(prev_tick, 1'b1);
            if ((q & dmask) !== (prev_q & dmask)) begin
                if (have_prev != 0) check(q & dmask, (prev_q + step) & dmask);
                have_prev = 1;
                chg++;
            end
            if (!w8) check({q[7:6], q[4], q[5]}, {3'h0, prev_ser});
            rises += int'(wrclk_out && !prev_wr);
        end
        if (rst_n) check(wrclk_p1, 1'b0);
        prev_q = q;
        prev_empty = empty;
        prev_tick = rd_tick;
        prev_ser = serial_in;
        prev_wr = wrclk_out;
    end

    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        {psel, penable, pwrite, paddr, pwdata, serial_in, stall, mon, run, sync_on} = '0;
        {width8, w8, phase, n, num_errors, check_count} = '0;
        width8 = 1'b1;
        w8 = 1'b1;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        apb(1'b0, rx_fifo_pkg::CTRL_OFFSET, 32'h0);
        check(rd, 32'h1);
        apb(1'b0, rx_fifo_pkg::STATUS_OFFSET, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, rx_fifo_pkg::MASK_OFFSET, 32'h0);
        check(rd, 32'h0);
        apb(1'b1, rx_fifo_pkg::PTRS_OFFSET, 32'hff);
        apb(1'b0, rx_fifo_pkg::PTRS_OFFSET, 32'h0);
        check(rd, 32'h80);
        apb(1'b0, 12'h010, 32'h0);
        check({err, rd[30:0]}, 32'h80000000);
        // Width eight at an unrelated reader phase, then the event bits.
        start(32'h5, 3'h3, 8);
        apb(1'b0, rx_fifo_pkg::STATUS_OFFSET, 32'h0);
        check(rd, 32'h2);
        check(irq, 1'b0);
        apb(1'b1, rx_fifo_pkg::MASK_OFFSET, 32'h2);
        repeat (3) @(posedge clk);
        check(irq, 1'b1);
        apb(1'b1, rx_fifo_pkg::STATUS_OFFSET, 32'h2);
        repeat (3) @(posedge clk);
        check(irq, 1'b0);
        // A stalled reader: the read pointer freezes while writes overrun it and q keeps refreshing.
        mon = 1'b0;
        stall <= 1'b1;
        repeat (24) @(posedge clk);
        have_prev = 0;
        step = 8'h8;
        chg = 0;
        mon = 1'b1;
        apb(1'b0, rx_fifo_pkg::PTRS_OFFSET, 32'h0);
        p1 = rd;
        repeat (300) @(posedge clk);
        apb(1'b0, rx_fifo_pkg::PTRS_OFFSET, 32'h0);
        check(rd[2:0], p1[2:0]);
        check(rd[6:4] != p1[6:4], 1'b1);
        check(chg >= 3, 1'b1);
        apb(1'b0, rx_fifo_pkg::STATUS_OFFSET, 32'h0);
        check(rd, 32'h3);
        check(irq, 1'b1);
        mon = 1'b0;
        stall <= 1'b0;
        apb(1'b1, rx_fifo_pkg::CTRL_OFFSET, 32'h1);
        repeat (20) @(posedge clk);
        apb(1'b0, rx_fifo_pkg::PTRS_OFFSET, 32'h0);
        check(rd, 32'h80);
        apb(1'b1, rx_fifo_pkg::STATUS_OFFSET, 32'h3);
        repeat (3) @(posedge clk);
        check(irq, 1'b0);
        // Width four with its serial copy, then the synchronous mode.
        start(32'h4, 3'h1, 4);
        mon = 1'b0;
        apb(1'b1, rx_fifo_pkg::CTRL_OFFSET, 32'h1);
        start(32'h7, 3'h6, 8);
        mon = 1'b0;
        stop_test();
    end
endmodule
